// *** src/caj_consts.svh ***
// Purpose: Shared constants for the byte/word execution unit
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Types live in caj_pkg; numbers live here
`ifndef CAJ_CONSTS_SVH
`define CAJ_CONSTS_SVH
`define CAJ_FLAGS_W    6
`define CAJ_FLG_C      0
`define CAJ_FLG_Z      1
`define CAJ_FLG_N      2
`define CAJ_FLG_V      3
`define CAJ_FLG_S      4
`define CAJ_FLG_H      5
`define CAJ_FLAGS_RST  6'h00
`define CAJ_HALF_BIT   3
`define CAJ_MSB8       7
`define CAJ_MSB16      15
`define CAJ_BYTE_ALL   8'hff
`define CAJ_BYTE_ZERO  8'h00
`define CAJ_WORD_ZERO  16'h0000
`define CAJ_CYC_ONE    2'h1
`define CAJ_CYC_TWO    2'h2
`define CAJ_CYC_THREE  2'h3
`define CAJ_REM_RST    2'h0
`define CAJ_PC_STEP    16'h0001
`define CAJ_SKIP_SHORT 16'h0002
`define CAJ_SKIP_LONG  16'h0003
`endif

// *** src/caj_pkg.sv ***
// Purpose: Types for the execution unit
// Assumes: Opcode decoded upstream
// Notes:   Constants are in caj_consts.svh
`default_nettype none
package caj_pkg;
    typedef enum logic [4:0] {
        op_sum               = 5'h00,
        op_sum_carry         = 5'h01,
        op_word_immediate_sum = 5'h02,
        op_minus             = 5'h03,
        op_minus_constant    = 5'h04,
        op_minus_with_borrow = 5'h05,
        op_minus_constant_with_borrow = 5'h06,
        op_word_immediate_minus = 5'h07,
        op_conjunction       = 5'h08,
        op_conjunction_with_constant = 5'h09,
        op_disjunction       = 5'h0a,
        op_disjunction_with_constant = 5'h0b,
        op_set_bits_by_mask  = 5'h0c,
        op_clear_bits_by_mask = 5'h0d,
        op_zero_sign_check   = 5'h0e,
        op_pointer_jump      = 5'h0f,
        op_pointer_call      = 5'h10,
        op_compare_skip_equal = 5'h11
    } caj_op_t;
    typedef enum logic {
        caj_st_idle = 1'b0,
        caj_st_busy = 1'b1
    } caj_state_t;
endpackage
`default_nettype wire

// *** src/caj_arith_if.sv ***
// Purpose: Operands and results between the core and an adder
// Assumes: Purely combinational path
// Notes:   One instance per adder width
`default_nettype none
interface caj_arith_if #(parameter int W = 8);
    logic [W-1:0] opa;
    logic [W-1:0] opb;
    logic [W-1:0] res;
    logic         cin;
    logic         sub;
    logic         cout;
    logic         ovf;
    logic         half;
    modport drv  (output opa, opb, cin, sub, input res, cout, ovf, half);
    modport unit (input opa, opb, cin, sub, output res, cout, ovf, half);
endinterface
`default_nettype wire

// *** src/caj_addsub.sv ***
// Purpose: Add or subtract with carry/borrow in, flag terms out
// Assumes: W at least the half-carry position plus one
// Notes:   cout is the borrow when subtracting
`default_nettype none
`include "caj_consts.svh"
module caj_addsub #(parameter int W = 8) (
    caj_arith_if.unit ar
);
    logic [W:0] wide;
    logic       a;
    logic       b;
    logic       r;
    logic       a3;
    logic       b3;
    logic       r3;
    always_comb begin
        if (ar.sub) begin
            wide = {1'b0, ar.opa} - {1'b0, ar.opb} - {{W{1'b0}}, ar.cin};
        end else begin
            wide = {1'b0, ar.opa} + {1'b0, ar.opb} + {{W{1'b0}}, ar.cin};
        end
        ar.res  = wide[W-1:0];
        ar.cout = wide[W];
        a  = ar.opa[W-1];
        b  = ar.opb[W-1];
        r  = wide[W-1];
        a3 = ar.opa[`CAJ_HALF_BIT];
        b3 = ar.opb[`CAJ_HALF_BIT];
        r3 = wide[`CAJ_HALF_BIT];
        if (ar.sub) begin
            ar.ovf  = (a & ~b & ~r) | (~a & b & r);
            ar.half = (~a3 & b3) | (b3 & r3) | (r3 & ~a3);
        end else begin
            ar.ovf  = (a & b & ~r) | (~a & ~b & r);
            ar.half = (a3 & b3) | (b3 & ~r3) | (~r3 & a3);
        end
    end
endmodule
`default_nettype wire

// *** src/caj_logic.sv ***
// Purpose: Byte AND / OR / mask operations
// Assumes: Operand b already chosen by the core
// Notes:   Unlisted opcodes pass a through
`default_nettype none
`include "caj_consts.svh"
module caj_logic (
    input  wire caj_pkg::caj_op_t i_op,
    input  wire logic [7:0]       i_a,
    input  wire logic [7:0]       i_b,
    output logic [7:0]            o_res
);
    always_comb begin
        case (i_op)
            caj_pkg::op_conjunction,
            caj_pkg::op_conjunction_with_constant,
            caj_pkg::op_zero_sign_check: o_res = i_a & i_b;
            caj_pkg::op_disjunction,
            caj_pkg::op_disjunction_with_constant,
            caj_pkg::op_set_bits_by_mask: o_res = i_a | i_b;
            caj_pkg::op_clear_bits_by_mask: o_res = i_a & (`CAJ_BYTE_ALL - i_b);
            default: o_res = i_a;
        endcase
    end
endmodule
`default_nettype wire

// *** src/caj_alu_core.sv ***
// Purpose: Execute one instruction: result, flags, PC and timing
// Assumes: Operands stable in the accept cycle; i_skip_long same clock
// Notes:   Results commit on o_done; flags visible the cycle after
`default_nettype none
`include "caj_consts.svh"
module caj_alu_core (
    input  wire logic               i_clk_sys,
    input  wire logic               i_srst,
    input  wire logic               i_op_valid,
    input  wire caj_pkg::caj_op_t   i_op,
    input  wire logic [7:0]         i_rd,
    input  wire logic [7:0]         i_rr,
    input  wire logic [7:0]         i_imm,
    input  wire logic [15:0]        i_pair,
    input  wire logic [15:0]        i_z,
    input  wire logic [15:0]        i_pc,
    input  wire logic               i_skip_long,
    output logic                    o_ready,
    output logic                    o_done,
    output logic                    o_rd_wr,
    output logic [7:0]              o_rd_val,
    output logic                    o_pair_wr,
    output logic [15:0]             o_pair_val,
    output logic                    o_pc_wr,
    output logic [15:0]             o_pc_val,
    output logic                    o_push,
    output logic [15:0]             o_ret_addr,
    output logic [`CAJ_FLAGS_W-1:0] o_flags
);
    caj_pkg::caj_state_t     state_q;
    caj_pkg::caj_state_t     state_d;
    logic [1:0]              rem_q;
    logic [1:0]              rem_d;
    logic [7:0]              res8_q;
    logic [7:0]              res8_d;
    logic [15:0]             res16_q;
    logic [15:0]             res16_d;
    logic [15:0]             pc_q;
    logic [15:0]             pc_d;
    logic [15:0]             ret_q;
    logic [15:0]             ret_d;
    logic                    wr8_q;
    logic                    wr8_d;
    logic                    wr16_q;
    logic                    wr16_d;
    logic                    pcw_q;
    logic                    pcw_d;
    logic                    push_q;
    logic                    push_d;
    logic [`CAJ_FLAGS_W-1:0] flags_q;
    logic [`CAJ_FLAGS_W-1:0] flags_d;
    logic [`CAJ_FLAGS_W-1:0] pflags_q;
    logic [`CAJ_FLAGS_W-1:0] pflags_d;
    logic [`CAJ_FLAGS_W-1:0] cur_flags;
    logic [`CAJ_FLAGS_W-1:0] f;
    logic [7:0]              opnd8;
    logic [7:0]              lg_res;
    logic                    is_const;
    logic                    is_logic;
    logic                    accept;

    caj_arith_if #(.W(8))  a8 ();
    caj_arith_if #(.W(16)) a16 ();

    caj_addsub #(.W(8))  u_add8  (.ar(a8));
    caj_addsub #(.W(16)) u_add16 (.ar(a16));
    caj_logic            u_logic (.i_op(i_op), .i_a(i_rd), .i_b(opnd8), .o_res(lg_res));

    assign o_done  = (state_q == caj_pkg::caj_st_busy) && (rem_q == `CAJ_CYC_ONE);
    // Ready in the finishing cycle keeps one-cycle ops back to back
    assign o_ready = (state_q == caj_pkg::caj_st_idle) || o_done;
    assign accept  = i_op_valid && o_ready;
    // Forward flags still pending so a chained carry op sees them
    assign cur_flags = o_done ? pflags_q : flags_q;

    always_comb begin
        is_const = i_op inside {caj_pkg::op_minus_constant, caj_pkg::op_minus_constant_with_borrow,
                                caj_pkg::op_conjunction_with_constant, caj_pkg::op_disjunction_with_constant,
                                caj_pkg::op_set_bits_by_mask, caj_pkg::op_clear_bits_by_mask};
        is_logic = i_op inside {caj_pkg::op_conjunction, caj_pkg::op_conjunction_with_constant,
                                caj_pkg::op_disjunction, caj_pkg::op_disjunction_with_constant,
                                caj_pkg::op_set_bits_by_mask, caj_pkg::op_clear_bits_by_mask,
                                caj_pkg::op_zero_sign_check};
        if (i_op == caj_pkg::op_zero_sign_check) begin
            opnd8 = i_rd;
        end else if (is_const) begin
            opnd8 = i_imm;
        end else begin
            opnd8 = i_rr;
        end
        a8.opa  = i_rd;
        a8.opb  = opnd8;
        a8.sub  = i_op inside {caj_pkg::op_minus, caj_pkg::op_minus_constant,
                               caj_pkg::op_minus_with_borrow, caj_pkg::op_minus_constant_with_borrow};
        a8.cin  = (i_op inside {caj_pkg::op_sum_carry, caj_pkg::op_minus_with_borrow,
                                caj_pkg::op_minus_constant_with_borrow}) & cur_flags[`CAJ_FLG_C];
        a16.opa = i_pair;
        a16.opb = {`CAJ_BYTE_ZERO, i_imm};
        a16.sub = (i_op == caj_pkg::op_word_immediate_minus);
        a16.cin = 1'b0;
    end

    always_comb begin
        f        = cur_flags;
        state_d  = state_q;
        rem_d    = rem_q;
        res8_d   = res8_q;
        res16_d  = res16_q;
        pc_d     = pc_q;
        ret_d    = ret_q;
        wr8_d    = wr8_q;
        wr16_d   = wr16_q;
        pcw_d    = pcw_q;
        push_d   = push_q;
        pflags_d = pflags_q;
        flags_d  = o_done ? pflags_q : flags_q;
        case (state_q)
            caj_pkg::caj_st_idle: begin
            end
            caj_pkg::caj_st_busy: begin
                rem_d = rem_q - `CAJ_CYC_ONE;
                if (o_done) begin
                    state_d = caj_pkg::caj_st_idle;
                end
            end
            default: begin
            end
        endcase
        if (accept) begin
            state_d = caj_pkg::caj_st_busy;
            rem_d   = `CAJ_CYC_ONE;
            wr8_d   = 1'b0;
            wr16_d  = 1'b0;
            pcw_d   = 1'b0;
            push_d  = 1'b0;
            if (is_logic) begin
                res8_d = lg_res;
                wr8_d  = 1'b1;
                f[`CAJ_FLG_Z] = (lg_res == `CAJ_BYTE_ZERO);
                f[`CAJ_FLG_N] = lg_res[`CAJ_MSB8];
                f[`CAJ_FLG_V] = 1'b0;
                f[`CAJ_FLG_S] = lg_res[`CAJ_MSB8];
            end else begin
                case (i_op)
                    caj_pkg::op_sum,
                    caj_pkg::op_sum_carry,
                    caj_pkg::op_minus,
                    caj_pkg::op_minus_constant,
                    caj_pkg::op_minus_with_borrow,
                    caj_pkg::op_minus_constant_with_borrow: begin
                        res8_d = a8.res;
                        wr8_d  = 1'b1;
                        f[`CAJ_FLG_C] = a8.cout;
                        f[`CAJ_FLG_Z] = (a8.res == `CAJ_BYTE_ZERO);
                        f[`CAJ_FLG_N] = a8.res[`CAJ_MSB8];
                        f[`CAJ_FLG_V] = a8.ovf;
                        f[`CAJ_FLG_S] = a8.res[`CAJ_MSB8] ^ a8.ovf;
                        f[`CAJ_FLG_H] = a8.half;
                    end
                    caj_pkg::op_word_immediate_sum,
                    caj_pkg::op_word_immediate_minus: begin
                        res16_d = a16.res;
                        wr16_d  = 1'b1;
                        rem_d   = `CAJ_CYC_TWO;
                        f[`CAJ_FLG_C] = a16.cout;
                        f[`CAJ_FLG_Z] = (a16.res == `CAJ_WORD_ZERO);
                        f[`CAJ_FLG_N] = a16.res[`CAJ_MSB16];
                        f[`CAJ_FLG_V] = a16.ovf;
                        f[`CAJ_FLG_S] = a16.res[`CAJ_MSB16] ^ a16.ovf;
                    end
                    caj_pkg::op_pointer_jump: begin
                        pc_d  = i_z;
                        pcw_d = 1'b1;
                        rem_d = `CAJ_CYC_TWO;
                    end
                    caj_pkg::op_pointer_call: begin
                        pc_d   = i_z;
                        ret_d  = i_pc + `CAJ_PC_STEP;
                        pcw_d  = 1'b1;
                        push_d = 1'b1;
                        rem_d  = `CAJ_CYC_THREE;
                    end
                    caj_pkg::op_compare_skip_equal: begin
                        pcw_d = 1'b1;
                        // Skip cost depends on the length of the skipped instruction
                        if (i_rd == i_rr) begin
                            pc_d  = i_pc + (i_skip_long ? `CAJ_SKIP_LONG : `CAJ_SKIP_SHORT);
                            rem_d = i_skip_long ? `CAJ_CYC_THREE : `CAJ_CYC_TWO;
                        end else begin
                            pc_d  = i_pc + `CAJ_PC_STEP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            pflags_d = f;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_q  <= caj_pkg::caj_st_idle;
            rem_q    <= `CAJ_REM_RST;
            res8_q   <= `CAJ_BYTE_ZERO;
            res16_q  <= `CAJ_WORD_ZERO;
            pc_q     <= `CAJ_WORD_ZERO;
            ret_q    <= `CAJ_WORD_ZERO;
            wr8_q    <= 1'b0;
            wr16_q   <= 1'b0;
            pcw_q    <= 1'b0;
            push_q   <= 1'b0;
            flags_q  <= `CAJ_FLAGS_RST;
            pflags_q <= `CAJ_FLAGS_RST;
        end else begin
            state_q  <= state_d;
            rem_q    <= rem_d;
            res8_q   <= res8_d;
            res16_q  <= res16_d;
            pc_q     <= pc_d;
            ret_q    <= ret_d;
            wr8_q    <= wr8_d;
            wr16_q   <= wr16_d;
            pcw_q    <= pcw_d;
            push_q   <= push_d;
            flags_q  <= flags_d;
            pflags_q <= pflags_d;
        end
    end

    assign o_rd_wr    = o_done & wr8_q;
    assign o_pair_wr  = o_done & wr16_q;
    assign o_pc_wr    = o_done & pcw_q;
    assign o_push     = o_done & push_q;
    assign o_rd_val   = res8_q;
    assign o_pair_val = res16_q;
    assign o_pc_val   = pc_q;
    assign o_ret_addr = ret_q;
    assign o_flags    = flags_q;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    AST_SUM_ONE_CYCLE: assert property (
        accept && i_op == caj_pkg::op_sum |=> o_done && o_rd_wr && o_rd_val == 8'($past(i_rd) + $past(i_rr)))
        else $error("register sum wrong or late");
    AST_SUM_CARRY: assert property (
        accept && i_op == caj_pkg::op_sum_carry |=>
        o_done && o_rd_val == 8'($past(i_rd) + $past(i_rr) + {7'h00, $past(cur_flags[`CAJ_FLG_C])}))
        else $error("carry sum wrong");
    AST_WORD_SUM: assert property (
        accept && i_op == caj_pkg::op_word_immediate_sum |=> !o_done ##1
        (o_pair_wr && o_pair_val == 16'($past(i_pair, 2) + {8'h00, $past(i_imm, 2)})))
        else $error("word sum wrong or not two cycles");
    AST_MINUS: assert property (
        accept && i_op inside {caj_pkg::op_minus, caj_pkg::op_minus_constant} |=>
        o_rd_wr && o_rd_val == 8'($past(i_rd) - $past(opnd8)))
        else $error("subtract wrong");
    AST_BORROW_REG: assert property (
        accept && i_op == caj_pkg::op_minus_with_borrow |=>
        o_rd_wr && o_rd_val == 8'($past(i_rd) - $past(i_rr) - {7'h00, $past(cur_flags[`CAJ_FLG_C])}))
        else $error("borrow subtract wrong");
    AST_BORROW_CONST: assert property (
        accept && i_op == caj_pkg::op_minus_constant_with_borrow |=>
        o_rd_wr && o_rd_val == 8'($past(i_rd) - $past(i_imm) - {7'h00, $past(cur_flags[`CAJ_FLG_C])}))
        else $error("constant borrow subtract wrong");
    AST_WORD_MINUS: assert property (
        accept && i_op == caj_pkg::op_word_immediate_minus |=> !o_pair_wr ##1
        (o_pair_wr && o_pair_val == 16'($past(i_pair, 2) - {8'h00, $past(i_imm, 2)})))
        else $error("word subtract wrong or not two cycles");
    AST_CLEAR_MASK: assert property (
        accept && i_op == caj_pkg::op_clear_bits_by_mask |=> o_rd_wr && o_rd_val == ($past(i_rd) & ~$past(i_imm)))
        else $error("mask clear wrong");
    AST_SET_MASK: assert property (
        accept && i_op == caj_pkg::op_set_bits_by_mask |=> o_rd_wr && o_rd_val == ($past(i_rd) | $past(i_imm)))
        else $error("mask set wrong");
    AST_TEST_KEEPS: assert property (
        accept && i_op == caj_pkg::op_zero_sign_check |=> o_done && o_rd_val == $past(i_rd))
        else $error("test changed the register");
    AST_LOGIC_FLAGS: assert property (
        o_rd_wr && $past(accept && is_logic) |=> !o_flags[`CAJ_FLG_V]
        && o_flags[`CAJ_FLG_S] == o_flags[`CAJ_FLG_N] && $stable(o_flags[`CAJ_FLG_C]) && $stable(o_flags[`CAJ_FLG_H]))
        else $error("logical op touched wrong flags");
    AST_OR_RESULT: assert property (
        accept && i_op == caj_pkg::op_disjunction |=> o_rd_val == ($past(i_rd) | $past(i_rr)))
        else $error("or wrong");
    AST_JUMP: assert property (
        accept && i_op == caj_pkg::op_pointer_jump |=> !o_done ##1
        (o_pc_wr && o_pc_val == $past(i_z, 2) && !o_push) ##1 o_flags == $past(o_flags))
        else $error("pointer jump wrong");
    AST_CALL: assert property (
        accept && i_op == caj_pkg::op_pointer_call |=> !o_done [*2] ##1
        (o_pc_wr && o_push && o_pc_val == $past(i_z, 3)))
        else $error("pointer call wrong or not three cycles");
    AST_SKIP_NE: assert property (
        accept && i_op == caj_pkg::op_compare_skip_equal && i_rd != i_rr |=>
        o_pc_wr && o_pc_val == 16'($past(i_pc) + `CAJ_PC_STEP))
        else $error("unequal compare did not step");
    AST_ZERO_NEG: assert property (
        o_rd_wr |=> o_flags[`CAJ_FLG_Z] == ($past(o_rd_val) == `CAJ_BYTE_ZERO)
        && o_flags[`CAJ_FLG_N] == $past(o_rd_val[`CAJ_MSB8]))
        else $error("zero or negative flag wrong");
    AST_SIGN: assert property (
        o_rd_wr || o_pair_wr |=> o_flags[`CAJ_FLG_S] == (o_flags[`CAJ_FLG_N] ^ o_flags[`CAJ_FLG_V]))
        else $error("sign flag not N xor V");

    COV_WORD: cover property (accept && i_op == caj_pkg::op_word_immediate_sum);
    COV_CALL: cover property (o_push);
    COV_SKIP_LONG: cover property (accept && i_op == caj_pkg::op_compare_skip_equal && i_rd == i_rr && i_skip_long);
    COV_CHAIN: cover property (accept && o_done && i_op == caj_pkg::op_sum_carry);
endmodule
`default_nettype wire

// *** verification/caj_tb.sv ***
// Purpose: Self-checking bench for caj_alu_core
// Assumes: One clock, synchronous reset; Z pointer and PC held fixed
// Notes:   Flags of a row are checked at the accept edge of the next one
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        caj_pkg::caj_op_t op;
        logic [7:0]       rd, rr, imm;
        logic             lng;
        logic [1:0]       cyc;
        logic [2:0]       wr;
        logic [15:0]      res;
        logic [5:0]       flg;
    } caj_row_t;
    logic             clk, srst, vld, lng, ready, done, rd_wr, pair_wr, pc_wr, push;
    caj_pkg::caj_op_t op;
    logic [7:0]       rd, rr, imm, rd_val;
    logic [15:0]      pair, z, pc, pair_val, pc_val, ret;
    logic [5:0]       flags, prev;
    int               n_mismatch, total_checks;
    caj_row_t         rows [22];
    caj_alu_core dut (.i_clk_sys(clk), .i_srst(srst), .i_op_valid(vld), .i_op(op), .i_rd(rd), .i_rr(rr),
        .i_imm(imm), .i_pair(pair), .i_z(z), .i_pc(pc), .i_skip_long(lng), .o_ready(ready), .o_done(done),
        .o_rd_wr(rd_wr), .o_rd_val(rd_val), .o_pair_wr(pair_wr), .o_pair_val(pair_val), .o_pc_wr(pc_wr),
        .o_pc_val(pc_val), .o_push(push), .o_ret_addr(ret), .o_flags(flags));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flg(input logic [5:0] got, input logic [5:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: flags %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Word ops take the pair from rd:rr
    // Enum target kept out of a concatenation so no implicit cast is needed
    task automatic issue(input caj_row_t r);
        vld  <= 1'b1;
        op   <= r.op;
        rd   <= r.rd;
        rr   <= r.rr;
        imm  <= r.imm;
        pair <= {r.rd, r.rr};
        lng  <= r.lng;
    endtask
    task automatic run_row(input caj_row_t r);
        int n;
        issue(r);
        @(posedge clk);
        chk_flg(flags, prev);
        vld <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 8);
        chk_val(16'(n), 16'(r.cyc));
        chk_val({13'h0, rd_wr, pair_wr, pc_wr}, {13'h0, r.wr});
        chk_val({15'h0, push}, {15'h0, r.op == caj_pkg::op_pointer_call});
        chk_val(r.wr[2] ? {8'h00, rd_val} : (r.wr[1] ? pair_val : pc_val), r.res);
    endtask
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        srst = 1'b1;
        vld  = 1'b0;
        op   = caj_pkg::op_sum;
        rd   = 8'h00;
        rr   = 8'h00;
        imm  = 8'h00;
        pair = 16'h0000;
        lng  = 1'b0;
        z = 16'h4321;
        pc = 16'h0100;
        prev = 6'h00;
        rows = '{
            '{caj_pkg::op_sum, 8'h0f, 8'h01, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0010, 6'h20},
            '{caj_pkg::op_sum, 8'h7f, 8'h01, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0080, 6'h2c},
            '{caj_pkg::op_sum, 8'hff, 8'h01, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0000, 6'h23},
            '{caj_pkg::op_sum_carry, 8'h10, 8'h20, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0031, 6'h00},
            '{caj_pkg::op_minus, 8'h10, 8'h01, 8'h00, 1'b0, 2'h1, 3'h4, 16'h000f, 6'h20},
            '{caj_pkg::op_minus_constant, 8'h00, 8'h00, 8'h01, 1'b0, 2'h1, 3'h4, 16'h00ff, 6'h35},
            '{caj_pkg::op_minus_with_borrow, 8'h05, 8'h02, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0002, 6'h00},
            '{caj_pkg::op_minus_constant_with_borrow, 8'h80, 8'h00, 8'h01, 1'b0, 2'h1, 3'h4, 16'h007f, 6'h38},
            '{caj_pkg::op_word_immediate_sum, 8'hff, 8'hff, 8'h01, 1'b0, 2'h2, 3'h2, 16'h0000, 6'h23},
            '{caj_pkg::op_word_immediate_minus, 8'h80, 8'h00, 8'h01, 1'b0, 2'h2, 3'h2, 16'h7fff, 6'h38},
            '{caj_pkg::op_conjunction, 8'hf0, 8'h80, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0080, 6'h34},
            '{caj_pkg::op_conjunction_with_constant, 8'h0f, 8'h00, 8'hf0, 1'b0, 2'h1, 3'h4, 16'h0000, 6'h22},
            '{caj_pkg::op_disjunction, 8'h01, 8'h02, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0003, 6'h20},
            '{caj_pkg::op_disjunction_with_constant, 8'h00, 8'h00, 8'h80, 1'b0, 2'h1, 3'h4, 16'h0080, 6'h34},
            '{caj_pkg::op_set_bits_by_mask, 8'h01, 8'h00, 8'h40, 1'b0, 2'h1, 3'h4, 16'h0041, 6'h20},
            '{caj_pkg::op_clear_bits_by_mask, 8'hff, 8'h00, 8'h0f, 1'b0, 2'h1, 3'h4, 16'h00f0, 6'h34},
            '{caj_pkg::op_zero_sign_check, 8'h00, 8'hff, 8'h00, 1'b0, 2'h1, 3'h4, 16'h0000, 6'h22},
            '{caj_pkg::op_pointer_jump, 8'h00, 8'h00, 8'h00, 1'b0, 2'h2, 3'h1, 16'h4321, 6'h22},
            '{caj_pkg::op_pointer_call, 8'h00, 8'h00, 8'h00, 1'b0, 2'h3, 3'h1, 16'h4321, 6'h22},
            '{caj_pkg::op_compare_skip_equal, 8'h55, 8'h55, 8'h00, 1'b0, 2'h2, 3'h1, 16'h0102, 6'h22},
            '{caj_pkg::op_compare_skip_equal, 8'h55, 8'h55, 8'h00, 1'b1, 2'h3, 3'h1, 16'h0103, 6'h22},
            '{caj_pkg::op_compare_skip_equal, 8'h55, 8'h54, 8'h00, 1'b1, 2'h1, 3'h1, 16'h0101, 6'h22}};
        repeat (5) @(posedge clk);
        chk_val({15'h0, ready}, 16'h0001);
        srst <= 1'b0;
        foreach (rows[i]) begin
            run_row(rows[i]);
            prev = rows[i].flg;
        end
        // Back to back: second request is taken in the done cycle, carry is forwarded
        issue(rows[2]);
        @(posedge clk);
        issue(rows[3]);
        @(posedge clk);
        chk_val({7'h0, done, rd_val}, 16'h0100);
        vld <= 1'b0;
        @(posedge clk);
        chk_val({7'h0, done, rd_val}, 16'h0131);
        // Request held during a call must not be taken before its done cycle
        issue(rows[18]);
        @(posedge clk);
        issue(rows[0]);
        for (int k = 1; k <= 3; k++) begin
            @(posedge clk);
            chk_val({15'h0, done}, {15'h0, k == 3});
        end
        chk_val(ret, 16'h0101);
        vld <= 1'b0;
        @(posedge clk);
        chk_val({7'h0, done, rd_val}, 16'h0110);
        // Reset in mid-operation clears everything
        issue(rows[20]);
        @(posedge clk);
        chk_flg(flags, rows[0].flg);
        srst <= 1'b1;
        vld <= 1'b0;
        repeat (2) @(posedge clk);
        chk_val({ready, done, pc_wr, 7'h0, flags}, 16'h8000);
        srst <= 1'b0;
        @(posedge clk);
        end_sim();
    end
endmodule
`default_nettype wire
